// file: tcc_pkg.sv
package tcc_pkg;
    localparam logic [7:0]  ADDR_CTRL_A   = 8'h00;
    localparam logic [7:0]  ADDR_CTRL_B   = 8'h04;
    localparam logic [7:0]  ADDR_COUNT    = 8'h08;
    localparam logic [7:0]  ADDR_CMP_A    = 8'h0C;
    localparam logic [7:0]  ADDR_CMP_B    = 8'h10;
    localparam logic [7:0]  ADDR_FLAGS    = 8'h14;
    localparam logic [7:0]  ADDR_IEN      = 8'h18;
    localparam logic [7:0]  ADDR_ACK      = 8'h1C;
    localparam int          WM_LO_POS     = 0;
    localparam int          ACT_B_POS     = 4;
    localparam int          ACT_A_POS     = 6;
    localparam int          CS_POS        = 0;
    localparam int          WM_HI_POS     = 3;
    localparam int          FLG_OVF_POS   = 0;
    localparam int          FLG_CA_POS    = 1;
    localparam int          FLG_CB_POS    = 2;
    localparam logic [7:0]  CNT_BOTTOM    = 8'h00;
    localparam logic [7:0]  CNT_MAX       = 8'hFF;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [2:0]  CS_STOP       = 3'h0;
    localparam logic [2:0]  CS_EXT_FALL   = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE   = 3'h7;
    localparam logic [2:0]  WM_NORMAL     = 3'h0;
    localparam logic [2:0]  WM_PC_MAX     = 3'h1;
    localparam logic [2:0]  WM_CTC        = 3'h2;
    localparam logic [2:0]  WM_FAST_MAX   = 3'h3;
    localparam logic [2:0]  WM_PC_CMP     = 3'h5;
    localparam logic [2:0]  WM_FAST_CMP   = 3'h7;
    localparam logic [10:0] DIV_8         = 11'h007;
    localparam logic [10:0] DIV_64        = 11'h03F;
    localparam logic [10:0] DIV_256       = 11'h0FF;
    localparam logic [10:0] DIV_1024      = 11'h3FF;
    typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} tcc_act_t;
endpackage

// file: tcc_top.sv
// What this block does
// - clear forces count value to zero
// - top flag when count equals top
// - bottom flag when count is zero
// - count changes only on timer tick or software count write
// - clock select picks source, zero stops
// - count readable and writable any time
// - software write beats clear or count
// - three-bit wave mode across two registers
// - overflow flag set per wave mode
// - overflow flag drives interrupt request
// - both compare values matched continuously
// - compare flag set on following tick
// - enabled compare flag raises interrupt
// - interrupt acknowledge clears compare flag
// - writing one clears flag, zero keeps
// - outputs formed from match, mode, action
// - top and bottom handle range ends
// - action field takes effect immediately
// - bottom is zero, max is 255
// - top is 255 or compare value a
// - count strobe with up/down direction
//
// The implementer's own choices: the address map and the APB interface to the registers.
module tcc_top (
    input  wire logic        MCLK_I,
    input  wire logic        NRST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic        EXT_CLK_I,
    input  wire logic [2:0]  INT_ACK_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             COMPARE_OUTPUT_A_O,
    output logic             COMPARE_OUTPUT_B_O,
    output logic             OVF_IRQ_O,
    output logic             CMP_A_IRQ_O,
    output logic             CMP_B_IRQ_O
);
    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [7:0]  count_value_q;
    logic [7:0]  cmp_q [2];
    logic [2:0]  ien_q;
    logic        overflow_flag_q;
    logic [1:0]  cmp_flag_q;
    logic [1:0]  cmp_hit;
    logic        wr_block_q;
    logic        dir_down_q;
    logic [1:0]  wave_q;
    logic [10:0] pre_q;
    logic        ext_q;
    logic        timer_tick;
    logic [2:0]  clock_select_field;
    logic [2:0]  wave_mode_field;
    logic [7:0]  top_val;
    logic        at_top;
    logic        at_bottom;
    logic        at_max;
    logic [1:0]  match;
    logic        wr_en;
    logic        acc;
    logic        is_pwm;
    logic        is_pc;
    logic        clear_sig;
    logic        count_strobe;
    logic        going_down;
    logic        ovf_set;
    logic [7:0]  count_d;

    assign acc = PSEL_I & PENABLE_I;
    assign wr_en = acc & PWRITE_I;
    // low two bits in control a, high bit in control b
    assign wave_mode_field = {ctrl_b_q[tcc_pkg::WM_HI_POS], ctrl_a_q[tcc_pkg::WM_LO_POS +: 2]};
    assign clock_select_field = ctrl_b_q[tcc_pkg::CS_POS +: 3];
    assign is_pc = (wave_mode_field == tcc_pkg::WM_PC_MAX)
                 | (wave_mode_field == tcc_pkg::WM_PC_CMP);
    assign is_pwm = is_pc | (wave_mode_field == tcc_pkg::WM_FAST_MAX)
                  | (wave_mode_field == tcc_pkg::WM_FAST_CMP);

    // prescaler taps; external input sampled once so edges are single-cycle
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            pre_q <= 11'h000;
            ext_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 11'h001;
            ext_q <= EXT_CLK_I;
        end
    end

    always_comb begin
        case (clock_select_field)
            tcc_pkg::CS_STOP:     timer_tick = 1'b0;
            3'h1:                 timer_tick = 1'b1;
            3'h2:                 timer_tick = (pre_q[2:0] == tcc_pkg::DIV_8[2:0]);
            3'h3:                 timer_tick = (pre_q[5:0] == tcc_pkg::DIV_64[5:0]);
            3'h4:                 timer_tick = (pre_q[7:0] == tcc_pkg::DIV_256[7:0]);
            3'h5:                 timer_tick = (pre_q == tcc_pkg::DIV_1024);
            tcc_pkg::CS_EXT_FALL: timer_tick = ext_q & ~EXT_CLK_I;
            tcc_pkg::CS_EXT_RISE: timer_tick = ~ext_q & EXT_CLK_I;
            default:              timer_tick = 1'b0;
        endcase
    end

    assign top_val = (wave_mode_field == tcc_pkg::WM_CTC) | (wave_mode_field == tcc_pkg::WM_PC_CMP)
                   | (wave_mode_field == tcc_pkg::WM_FAST_CMP) ? cmp_q[0] : tcc_pkg::CNT_MAX;
    assign at_top    = (count_value_q == top_val);
    assign at_bottom = (count_value_q == tcc_pkg::CNT_BOTTOM);
    assign at_max    = (count_value_q == tcc_pkg::CNT_MAX);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cmp
            assign match[g] = (count_value_q == cmp_q[g]);
        end
    endgenerate

    // direction for dual-slope; up otherwise
    // never step below bottom, even while the stored direction is still down
    assign going_down = is_pc & ~at_bottom & (dir_down_q | at_top);
    assign clear_sig = ~is_pc & at_top & (wave_mode_field != tcc_pkg::WM_NORMAL);
    assign count_strobe = ~clear_sig;
    assign ovf_set = timer_tick & (is_pc ? at_bottom & dir_down_q
                   : (wave_mode_field == tcc_pkg::WM_FAST_MAX) | (wave_mode_field == tcc_pkg::WM_FAST_CMP)
                   ? at_top : at_max);

    always_comb begin
        count_d = count_value_q;
        if (timer_tick) begin
            if (clear_sig)
                count_d = tcc_pkg::CNT_BOTTOM;
            else if (count_strobe && going_down)
                count_d = count_value_q - 8'h01;
            else if (count_strobe)
                count_d = count_value_q + 8'h01;
        end
        if (wr_en && PADDR_I == tcc_pkg::ADDR_COUNT)
            count_d = PWDATA_I[7:0];
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            count_value_q <= tcc_pkg::RST_BYTE;
            dir_down_q    <= 1'b0;
        end else begin
            count_value_q <= count_d;
            if (timer_tick && is_pc) begin
                if (at_top && !at_bottom)
                    dir_down_q <= 1'b1;
                else if (at_bottom)
                    dir_down_q <= 1'b0;
            end
        end
    end

    // software registers
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            ctrl_a_q <= tcc_pkg::RST_BYTE;
            ctrl_b_q <= tcc_pkg::RST_BYTE;
            cmp_q[0] <= tcc_pkg::RST_BYTE;
            cmp_q[1] <= tcc_pkg::RST_BYTE;
            ien_q    <= 3'h0;
        end else if (wr_en) begin
            case (PADDR_I)
                tcc_pkg::ADDR_CTRL_A: ctrl_a_q <= PWDATA_I[7:0];
                tcc_pkg::ADDR_CTRL_B: ctrl_b_q <= PWDATA_I[7:0];
                tcc_pkg::ADDR_CMP_A:  cmp_q[0] <= PWDATA_I[7:0];
                tcc_pkg::ADDR_CMP_B:  cmp_q[1] <= PWDATA_I[7:0];
                tcc_pkg::ADDR_IEN:    ien_q    <= PWDATA_I[2:0];
                default:              ;
            endcase
        end
    end

    // a match standing at a tick sets the flag as the count moves on;
    // a count write masks the compare through the next tick
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            wr_block_q <= 1'b0;
        end else begin
            if (wr_en && PADDR_I == tcc_pkg::ADDR_COUNT)
                wr_block_q <= 1'b1;
            else if (timer_tick)
                wr_block_q <= 1'b0;
        end
    end
    assign cmp_hit = match & {2{~wr_block_q}};

    // flags: hardware set wins over software or acknowledge clear
    logic       flag_wr;
    assign flag_wr = wr_en & (PADDR_I == tcc_pkg::ADDR_FLAGS);
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            overflow_flag_q <= 1'b0;
            cmp_flag_q      <= 2'h0;
        end else begin
            if (ovf_set)
                overflow_flag_q <= 1'b1;
            else if ((flag_wr && PWDATA_I[tcc_pkg::FLG_OVF_POS]) || INT_ACK_I[0])
                overflow_flag_q <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                if (timer_tick && cmp_hit[i])
                    cmp_flag_q[i] <= 1'b1;
                else if ((flag_wr && PWDATA_I[tcc_pkg::FLG_CA_POS + i]) || INT_ACK_I[1 + i])
                    cmp_flag_q[i] <= 1'b0;
            end
        end
    end

    // waveform generator; action field used directly
    for (g = 0; g < 2; g++) begin : g_wave
        tcc_pkg::tcc_act_t act;
        assign act = tcc_pkg::tcc_act_t'(ctrl_a_q[(g == 0 ? tcc_pkg::ACT_A_POS
                                                          : tcc_pkg::ACT_B_POS) +: 2]);
        always_ff @(posedge MCLK_I) begin
            if (!NRST_I) begin
                wave_q[g] <= 1'b0;
            end else if (timer_tick && act != tcc_pkg::ACT_NONE) begin
                if (!is_pwm) begin
                    if (match[g])
                        case (act)
                            tcc_pkg::ACT_TOGGLE: wave_q[g] <= ~wave_q[g];
                            tcc_pkg::ACT_CLEAR:  wave_q[g] <= 1'b0;
                            tcc_pkg::ACT_SET:    wave_q[g] <= 1'b1;
                            default:             ;
                        endcase
                end else if (act[1]) begin
                    if (!is_pc && at_top)
                        wave_q[g] <= ~act[0];
                    else if (match[g])
                        wave_q[g] <= is_pc ? (act[0] ^ ~going_down) : act[0];
                end
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            COMPARE_OUTPUT_A_O <= 1'b0;
            COMPARE_OUTPUT_B_O <= 1'b0;
            OVF_IRQ_O          <= 1'b0;
            CMP_A_IRQ_O        <= 1'b0;
            CMP_B_IRQ_O        <= 1'b0;
        end else begin
            COMPARE_OUTPUT_A_O <= wave_q[0];
            COMPARE_OUTPUT_B_O <= wave_q[1];
            OVF_IRQ_O          <= overflow_flag_q & ien_q[0];
            CMP_A_IRQ_O        <= cmp_flag_q[0] & ien_q[1];
            CMP_B_IRQ_O        <= cmp_flag_q[1] & ien_q[2];
        end
    end

    // apb: reads answered in the access cycle from a registered copy
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            PRDATA_O  <= 32'h0000_0000;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            if (PSEL_I && !PENABLE_I && !PWRITE_I)
                case (PADDR_I)
                    tcc_pkg::ADDR_CTRL_A: PRDATA_O <= {24'h0, ctrl_a_q};
                    tcc_pkg::ADDR_CTRL_B: PRDATA_O <= {24'h0, ctrl_b_q};
                    tcc_pkg::ADDR_COUNT:  PRDATA_O <= {24'h0, count_d};
                    tcc_pkg::ADDR_CMP_A:  PRDATA_O <= {24'h0, cmp_q[0]};
                    tcc_pkg::ADDR_CMP_B:  PRDATA_O <= {24'h0, cmp_q[1]};
                    tcc_pkg::ADDR_FLAGS:  PRDATA_O <= {29'h0, cmp_flag_q, overflow_flag_q};
                    tcc_pkg::ADDR_IEN:    PRDATA_O <= {29'h0, ien_q};
                    default:              PSLVERR_O <= 1'b1;
                endcase
            else if (PSEL_I && !PENABLE_I && PADDR_I > tcc_pkg::ADDR_IEN)
                PSLVERR_O <= 1'b1;
        end
    end

    stop_holds_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (clock_select_field == tcc_pkg::CS_STOP && !wr_en) |=> $stable(count_value_q))
        else $error("count moved while stopped");
    write_wins_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (wr_en && PADDR_I == tcc_pkg::ADDR_COUNT) |=> count_value_q == $past(PWDATA_I[7:0]))
        else $error("count write lost");
    ctc_clear_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && wave_mode_field == tcc_pkg::WM_CTC && at_top && !wr_en)
        |=> count_value_q == tcc_pkg::CNT_BOTTOM)
        else $error("ctc did not clear");
    normal_ovf_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && wave_mode_field == tcc_pkg::WM_NORMAL && at_max) |=> overflow_flag_q)
        else $error("overflow not set");
    flag_clear_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (flag_wr && PWDATA_I[tcc_pkg::FLG_CA_POS] && !(timer_tick && cmp_hit[0]))
        |=> !cmp_flag_q[0])
        else $error("flag a not cleared");
    flag_keep_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (flag_wr && !PWDATA_I[tcc_pkg::FLG_CA_POS] && !INT_ACK_I[1] && cmp_flag_q[0])
        |=> cmp_flag_q[0])
        else $error("flag a lost on zero write");
    irq_follow_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        ##1 CMP_A_IRQ_O == $past(cmp_flag_q[0] & ien_q[1]))
        else $error("compare irq wrong");
    ovf_irq_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        ##1 OVF_IRQ_O == $past(overflow_flag_q & ien_q[0]))
        else $error("overflow irq wrong");
    flag_next_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && cmp_hit[1]) |=> cmp_flag_q[1])
        else $error("flag b not set");
    ack_clear_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (INT_ACK_I[2] && !(timer_tick && cmp_hit[1])) |=> !cmp_flag_q[1])
        else $error("ack did not clear");
    top_flag_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (wave_mode_field == tcc_pkg::WM_CTC) |-> (at_top == (count_value_q == cmp_q[0])))
        else $error("top indication wrong");
    bottom_flag_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        at_bottom == (count_value_q == 8'h00))
        else $error("bottom indication wrong");
    no_tick_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (!timer_tick && !wr_en) |=> $stable(count_value_q))
        else $error("count moved without tick");
    up_step_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && wave_mode_field == tcc_pkg::WM_NORMAL && !wr_en)
        |=> count_value_q == $past(count_value_q) + 8'h01)
        else $error("normal step wrong");
    down_step_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && is_pc && going_down && !wr_en)
        |=> count_value_q == $past(count_value_q) - 8'h01)
        else $error("down step wrong");
    pc_ovf_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && is_pc && at_bottom && dir_down_q) |=> overflow_flag_q)
        else $error("dual slope overflow missed");
    cmp_flag_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && cmp_hit[0]) |=> cmp_flag_q[0])
        else $error("flag a not set");
    write_mask_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (wr_en && PADDR_I == tcc_pkg::ADDR_COUNT) |=> cmp_hit == 2'h0)
        else $error("count write did not mask");
    reset_clear_a: assert property (@(posedge MCLK_I)
        !NRST_I |=> (count_value_q == 8'h00 && !overflow_flag_q && cmp_flag_q == 2'h0))
        else $error("reset left state");
    set_action_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && !is_pwm && match[0]
         && ctrl_a_q[tcc_pkg::ACT_A_POS +: 2] == tcc_pkg::ACT_SET) |=> wave_q[0])
        else $error("set action missed");
    clr_action_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && !is_pwm && match[1]
         && ctrl_a_q[tcc_pkg::ACT_B_POS +: 2] == tcc_pkg::ACT_CLEAR) |=> !wave_q[1])
        else $error("clear action missed");
    fast_top_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (timer_tick && is_pwm && !is_pc && at_top
         && ctrl_a_q[tcc_pkg::ACT_A_POS +: 2] == tcc_pkg::ACT_CLEAR) |=> wave_q[0])
        else $error("fast output not set at top");
    out_follow_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        ##1 COMPARE_OUTPUT_A_O == $past(wave_q[0]))
        else $error("output a lags wrongly");
    count_read_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (acc && !PWRITE_I && PADDR_I == tcc_pkg::ADDR_COUNT) |-> PRDATA_O[7:0] == count_value_q)
        else $error("count read wrong");
    ctc_cov: cover property (@(posedge MCLK_I) wave_mode_field == tcc_pkg::WM_CTC && clear_sig
        && timer_tick);
    pc_cov: cover property (@(posedge MCLK_I) is_pc && ovf_set);
    set_clr_cov: cover property (@(posedge MCLK_I) timer_tick && cmp_hit[0] && flag_wr);
    wr_tick_cov: cover property (@(posedge MCLK_I) timer_tick && wr_en
        && PADDR_I == tcc_pkg::ADDR_COUNT);
endmodule

// file: timer8_counter_compare_core_test.sv
module timer8_counter_compare_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk       = 1'b0;
    logic        nrst      = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h00000000;
    logic        ext_clk   = 1'b0;
    logic [2:0]  int_ack   = 3'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        out_a;
    logic        out_b;
    logic        ovf_irq;
    logic        cmp_a_irq;
    logic        cmp_b_irq;
    int          mismatches = 0;
    int          compares   = 0;
    int          cycles     = 0;

    tcc_top i_tcc_top (
        .MCLK_I             (clk),
        .NRST_I             (nrst),
        .PSEL_I             (psel),
        .PENABLE_I          (penable),
        .PWRITE_I           (pwrite),
        .PADDR_I            (paddr),
        .PWDATA_I           (pwdata),
        .EXT_CLK_I          (ext_clk),
        .INT_ACK_I          (int_ack),
        .PRDATA_O           (prdata),
        .PREADY_O           (pready),
        .PSLVERR_O          (pslverr),
        .COMPARE_OUTPUT_A_O (out_a),
        .COMPARE_OUTPUT_B_O (out_b),
        .OVF_IRQ_O          (ovf_irq),
        .CMP_A_IRQ_O        (cmp_a_irq),
        .CMP_B_IRQ_O        (cmp_b_irq)
    );

    always #50 clk = ~clk;

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole run needs about four hundred cycles; the 20000-cycle budget lies far above that, so only a hang reaches it
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer; an idle edge follows so back-to-back calls never re-drive psel in one step
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] d;
        logic        e;
        apb(1'b1, addr, {24'h000000, data}, d, e);
    endtask

    task automatic rd(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp,
                      input string what);
        logic [31:0] d;
        logic        e;
        apb(1'b0, addr, 32'h00000000, d, e);
        check(d & mask, exp, what);
    endtask

    // external source is edge detected after sync, so each level is held several cycles
    task automatic ext_level(input logic v);
        ext_clk <= v;
        repeat (6) @(posedge clk);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            ext_level(1'b1);
            ext_level(1'b0);
        end
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic        e;
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000000, "count after reset");
        rd(tcc_pkg::ADDR_FLAGS, 32'hFFFFFFFF, 32'h00000000, "flags after reset");
        check({29'h0, out_a, out_b, ovf_irq}, 32'h00000000, "outputs after reset");
        apb(1'b0, tcc_pkg::ADDR_ACK, 32'h00000000, d, e);
        check({31'h0, e}, 32'h00000001, "unmapped error");
        check(d, 32'h00000000, "unmapped read data");
    endtask

    task automatic t_stop();
        wr(tcc_pkg::ADDR_CTRL_B, 8'h00);
        wr(tcc_pkg::ADDR_COUNT, 8'h55);
        pulse(2);
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000055, "stopped count");
    endtask

    task automatic t_overflow();
        wr(tcc_pkg::ADDR_CTRL_A, 8'h00);
        wr(tcc_pkg::ADDR_CTRL_B, 8'h07);
        wr(tcc_pkg::ADDR_COUNT, 8'hFE);
        pulse(1);
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h000000FF, "count at max");
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000000, "no overflow yet");
        pulse(1);
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000000, "wrap to bottom");
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000001, "overflow set");
        wr(tcc_pkg::ADDR_IEN, 8'h01);
        repeat (3) @(posedge clk);
        check({31'h0, ovf_irq}, 32'h00000001, "overflow irq");
        wr(tcc_pkg::ADDR_FLAGS, 8'h00);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000001, "zero write keeps");
        wr(tcc_pkg::ADDR_FLAGS, 8'h01);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000000, "one write clears");
        repeat (3) @(posedge clk);
        check({31'h0, ovf_irq}, 32'h00000000, "overflow irq gone");
        wr(tcc_pkg::ADDR_CTRL_B, 8'h06);
        ext_level(1'b1);
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000000, "rise ignored");
        ext_level(1'b0);
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000001, "fall counted");
    endtask

    task automatic t_compare();
        wr(tcc_pkg::ADDR_CTRL_A, 8'h70);
        wr(tcc_pkg::ADDR_CTRL_B, 8'h07);
        wr(tcc_pkg::ADDR_CMP_A, 8'h12);
        wr(tcc_pkg::ADDR_CMP_B, 8'h12);
        wr(tcc_pkg::ADDR_IEN, 8'h06);
        wr(tcc_pkg::ADDR_COUNT, 8'h10);
        wr(tcc_pkg::ADDR_FLAGS, 8'h07);
        pulse(2);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000006, 32'h00000000, "flags not yet");
        pulse(1);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000006, 32'h00000006, "both flags set");
        repeat (3) @(posedge clk);
        check({30'h0, cmp_a_irq, cmp_b_irq}, 32'h00000003, "compare irqs");
        check({30'h0, out_a, out_b}, 32'h00000003, "toggle and set");
        int_ack <= 3'h2;
        @(posedge clk);
        int_ack <= 3'h0;
        repeat (3) @(posedge clk);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000006, 32'h00000004, "ack clears a");
        check({30'h0, cmp_a_irq, cmp_b_irq}, 32'h00000001, "irq a gone");
        wr(tcc_pkg::ADDR_FLAGS, 8'h07);
        wr(tcc_pkg::ADDR_COUNT, 8'h12);
        pulse(1);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000006, 32'h00000000, "write blocks match");
        wr(tcc_pkg::ADDR_CTRL_A, 8'hC0);
        wr(tcc_pkg::ADDR_COUNT, 8'h11);
        pulse(2);
        check({31'h0, out_a}, 32'h00000001, "new action used");
    endtask

    task automatic t_modes();
        wr(tcc_pkg::ADDR_IEN, 8'h00);
        wr(tcc_pkg::ADDR_CTRL_A, 8'h02);
        wr(tcc_pkg::ADDR_CMP_A, 8'h03);
        wr(tcc_pkg::ADDR_COUNT, 8'h00);
        pulse(3);
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000003, "ctc at top");
        pulse(1);
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000000, "ctc cleared");
        wr(tcc_pkg::ADDR_CTRL_A, 8'h03);
        wr(tcc_pkg::ADDR_CTRL_B, 8'h0F);
        wr(tcc_pkg::ADDR_CMP_A, 8'h02);
        wr(tcc_pkg::ADDR_FLAGS, 8'h07);
        pulse(2);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000000, "no overflow below top");
        pulse(1);
        rd(tcc_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000001, "fast overflow at top");
        rd(tcc_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000000, "fast wraps at cmp a");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_stop();
        t_overflow();
        t_compare();
        t_modes();
        summarize();
    end
endmodule
